// ---- rtl/tape_fsk_pkg.sv ----
// constants for the cassette FSK data recovery and clock generation block
// Function
// [RQ1] divide input clock by 55: six-bit counter runs 9 to 63, pulse and reload on carry
// [RQ2] five-stage binary up-counter gives divided clock outputs from its stages
// [RQ3] encoder clock rate chosen from the selected baud rate
// [RQ4] one positive pulse per rising or falling transition of the tape input
// [RQ5] edge pulse lasts until the delayed input copy catches up, a few microseconds
// [RQ6] serial-port mode forces the tape read data output high
// [RQ7] each edge pulse sets the recovered-clock flip-flop
// [RQ8] triggered one-shot counts 4 to 15, then resets the recovered clock
// [RQ9] interval shorter than one-shot width decodes as 1, longer as 0
// [RQ10] decoded bit is registered on the recovered clock before output
// [RQ11] multiplier tracks recovered clock and gives receiver a 16x data-rate clock; at 300 baud the x8 feedback gives 64x the data rate
// [RQ12] multiplier feedback ratio is 8 or 16 depending on baud rate
// [RQ13] lock output high while multiplier is in sync, brief glitches ignored
// [RQ14] receiver and transmitter clocks chosen from port mode and baud rate; the code picks the transmitter clock from baud rate alone
// [RQ15] 1200 baud: 1 is one 1200 Hz cycle, 0 half a 600 Hz cycle
// [RQ16] 300 baud: 1 is eight 2400 Hz cycles, 0 four 1200 Hz cycles
// [RQ17] tape input sampled by system clock; counters replace delay and loop; reset clears all (divider loads 9, one-shot count 4, HREADYOUT_O 1)
package tape_fsk_pkg;
  localparam int          CLK_MHZ         = 125;
  localparam logic [5:0]  DIV55_START     = 6'h09;
  localparam logic [5:0]  DIV55_LAST      = 6'h3F;
  localparam int          CPG_W           = 5;
  localparam logic [2:0]  ENC_SEL_1200    = 3'h3;
  localparam logic [2:0]  ENC_SEL_300     = 3'h4;
  localparam logic [2:0]  RS_SEL_1200     = 3'h0;
  localparam logic [2:0]  RS_SEL_300      = 3'h2;
  localparam int          EDGE_DELAY_NS   = 2000;
  localparam int          EDGE_DELAY_CYC  = (EDGE_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  OS_FIRST        = 4'h4;
  localparam logic [3:0]  OS_LAST         = 4'hF;
  localparam int          OS_STEP_US_1200 = 52;
  localparam int          OS_STEP_US_300  = 26;
  localparam int          OS_CYC_1200     = OS_STEP_US_1200 * CLK_MHZ;
  localparam int          OS_CYC_300      = OS_STEP_US_300 * CLK_MHZ;
  localparam int          PER_W           = 20;
  localparam logic [2:0]  FB_SHIFT_1200   = 3'h4;
  localparam logic [2:0]  FB_SHIFT_300    = 3'h3;
  localparam logic [2:0]  LOCK_NEED       = 3'h4;
  localparam logic [1:0]  LOCK_MISS       = 2'h2;
  localparam logic [3:0]  LOCK_TOL_SHIFT  = 4'h4;
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_IRQ_STAT    = 8'h08;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h0C;
  localparam logic [7:0]  OFS_PERIOD      = 8'h10;
  localparam int          CTRL_RS232_BIT  = 0;
  localparam int          CTRL_B300_BIT   = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;
  localparam int          IRQ_W           = 3;
  localparam int          IRQ_BIT_READY   = 0;
  localparam int          IRQ_LOCK_GAIN   = 1;
  localparam int          IRQ_LOCK_LOST   = 2;
  localparam logic [2:0]  IRQ_MASK_RESET  = 3'h0;
endpackage

// ---- rtl/tape_fsk_recovery.sv ----
// cassette FSK data recovery, clock generation and AHB-Lite register slave
module tape_fsk_recovery
  import tape_fsk_pkg::*;
#(
  parameter int OS_STEP_1200 = OS_CYC_1200,
  parameter int OS_STEP_300  = OS_CYC_300
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        TAPE_IN_I,
  output logic             TAPE_READ_DATA_O,
  output logic             REC_CLK_O,
  output logic             DIV55_O,
  output logic [4:0]       CPG_O,
  output logic             ENC_CLK_O,
  output logic             RX_CLK_O,
  output logic             TX_CLK_O,
  output logic             LOCK_O,
  output logic             IRQ_O
);

  localparam logic [15:0] OS_STEP_A = 16'(OS_STEP_1200 - 1);
  localparam logic [15:0] OS_STEP_B = 16'(OS_STEP_300 - 1);
  localparam logic [7:0]  EDGE_CYC  = 8'(EDGE_DELAY_CYC - 1);

  // bus slave state
  logic             dp_wr_r;
  logic             dp_rd_r;
  logic [7:0]       dp_addr_r;
  logic [1:0]       ctrl_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [31:0]      rd_nxt;
  logic             addr_ok;
  // clock generation
  logic [5:0]       div55_r;
  logic [CPG_W-1:0] cpg_r;
  // edge detector
  logic             tape_q_r;
  logic             tape_dly_r;
  logic [7:0]       dly_cnt_r;
  logic             edge_pulse_r;
  logic             edge_start;
  // decoder
  logic             os_run_r;
  logic [3:0]       os_cnt_r;
  logic [15:0]      os_pre_r;
  logic [15:0]      os_step;
  logic             os_fire;
  logic             rec_clk_r;
  logic             short_seen_r;
  logic             data_bit_r;
  logic             bit_ready;
  // multiplier
  logic [PER_W-1:0] per_cnt_r;
  logic [PER_W-1:0] per_meas_r;
  logic [PER_W-1:0] per_prev_r;
  logic [PER_W-1:0] half_step;
  logic [PER_W-1:0] mul_cnt_r;
  logic             mul_clk_r;
  logic [2:0]       fb_shift;
  logic [PER_W-1:0] per_diff;
  logic             per_match;
  logic [2:0]       good_cnt_r;
  logic [1:0]       miss_cnt_r;
  logic             lock_r;
  logic             rec_rise;

  logic             rs232_mode;
  logic             baud_300;
  logic [2:0]       enc_sel;
  logic [2:0]       rs_sel;

  assign rs232_mode = ctrl_r[CTRL_RS232_BIT];
  assign baud_300   = ctrl_r[CTRL_B300_BIT];

  // ---------------- AHB-Lite slave, zero wait states ----------------
  assign addr_ok = HSEL_I && HTRANS_I[1] && HREADY_I;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      dp_wr_r   <= 1'b0;
      dp_rd_r   <= 1'b0;
      dp_addr_r <= 8'h00;
    end else begin
      dp_wr_r   <= addr_ok && HWRITE_I;
      dp_rd_r   <= addr_ok && !HWRITE_I;
      dp_addr_r <= addr_ok ? HADDR_I[7:0] : dp_addr_r;
    end
  end

  // read data prepared in the address phase so it leaves a flip-flop
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (HADDR_I[31:8] == 24'h00_0000) begin
      unique case (HADDR_I[7:0])
        OFS_CTRL:     rd_nxt = {30'h0, ctrl_r};
        OFS_STATUS:   rd_nxt = {28'h0, tape_q_r, TAPE_READ_DATA_O, rec_clk_r, lock_r};
        OFS_IRQ_STAT: rd_nxt = {29'h0, irq_stat_r};
        OFS_IRQ_MASK: rd_nxt = {29'h0, irq_mask_r};
        OFS_PERIOD:   rd_nxt = {12'h000, per_meas_r};
        default:      rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      HRDATA_O    <= 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      HRDATA_O    <= (addr_ok && !HWRITE_I) ? rd_nxt : 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl_r     <= CTRL_RESET;
      irq_mask_r <= IRQ_MASK_RESET;
    end else if (dp_wr_r) begin
      if (dp_addr_r == OFS_CTRL)
        ctrl_r <= HWDATA_I[1:0];
      if (dp_addr_r == OFS_IRQ_MASK)
        irq_mask_r <= HWDATA_I[IRQ_W-1:0];
    end
  end

  // sticky events; a new event in the clearing cycle survives
  always_ff @(posedge CLK_I) begin
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    ev  = {3{1'b0}};
    clr = {3{1'b0}};
    ev[IRQ_BIT_READY] = bit_ready;
    ev[IRQ_LOCK_GAIN] = (good_cnt_r == LOCK_NEED - 3'h1) && per_match && rec_rise && !lock_r;
    ev[IRQ_LOCK_LOST] = (miss_cnt_r == LOCK_MISS - 2'h1) && !per_match && rec_rise && lock_r;
    if (dp_wr_r && dp_addr_r == OFS_IRQ_STAT)
      clr = HWDATA_I[IRQ_W-1:0];
    if (RST_I) begin
      irq_stat_r <= {IRQ_W{1'b0}};
      IRQ_O      <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~clr) | ev;
      IRQ_O      <= |(((irq_stat_r & ~clr) | ev) & irq_mask_r);
    end
  end

  // ---------------- clock generation ----------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      div55_r <= DIV55_START;
      DIV55_O <= 1'b0;
    end else begin
      div55_r <= (div55_r == DIV55_LAST) ? DIV55_START : div55_r + 6'h01; // see [RQ1]
      DIV55_O <= (div55_r == DIV55_LAST);                                 // see [RQ1]
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cpg_r <= {CPG_W{1'b0}};
    end else if (DIV55_O) begin
      cpg_r <= cpg_r + 5'h01; // see [RQ2]
    end
  end

  assign enc_sel = baud_300 ? ENC_SEL_300 : ENC_SEL_1200; // see [RQ3]
  assign rs_sel  = baud_300 ? RS_SEL_300 : RS_SEL_1200;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      CPG_O     <= 5'h00;
      ENC_CLK_O <= 1'b0;
      RX_CLK_O  <= 1'b0;
      TX_CLK_O  <= 1'b0;
    end else begin
      CPG_O     <= cpg_r;                                         // see [RQ2]
      ENC_CLK_O <= cpg_r[enc_sel];                                // see [RQ3]
      RX_CLK_O  <= rs232_mode ? cpg_r[rs_sel] : mul_clk_r;        // see [RQ14]
      TX_CLK_O  <= cpg_r[rs_sel];                                 // see [RQ14]
    end
  end

  // ---------------- edge detector ----------------
  // the delay line becomes a counter; a glitch shorter than it still starts an edge pulse, only the delayed copy ignores it
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      tape_q_r     <= 1'b0;
      tape_dly_r   <= 1'b0;
      dly_cnt_r    <= 8'h00;
      edge_pulse_r <= 1'b0;
    end else begin
      tape_q_r <= TAPE_IN_I; // see [RQ17]
      if (tape_q_r != tape_dly_r) begin
        dly_cnt_r <= dly_cnt_r + 8'h01;
        if (dly_cnt_r == EDGE_CYC) begin
          tape_dly_r <= tape_q_r; // see [RQ5]
          dly_cnt_r  <= 8'h00;
        end
      end else begin
        dly_cnt_r <= 8'h00;
      end
      edge_pulse_r <= (tape_q_r != tape_dly_r) && !(dly_cnt_r == EDGE_CYC); // see [RQ4]
    end
  end

  assign edge_start = (tape_q_r != tape_dly_r) && (dly_cnt_r == 8'h00) && !edge_pulse_r;

  // ---------------- decoder ----------------
  assign os_step = baud_300 ? OS_STEP_B : OS_STEP_A; // see [RQ15] [RQ16]
  assign os_fire = os_run_r && (os_cnt_r == OS_LAST) && (os_pre_r == os_step);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      os_run_r <= 1'b0;
      os_cnt_r <= OS_FIRST;
      os_pre_r <= 16'h0000;
    end else if (!os_run_r) begin
      if (edge_start) begin
        os_run_r <= 1'b1;      // see [RQ8]
        os_cnt_r <= OS_FIRST;  // see [RQ8]
        os_pre_r <= 16'h0000;
      end
    end else if (os_pre_r == os_step) begin
      os_pre_r <= 16'h0000;
      os_cnt_r <= os_cnt_r + 4'h1;
      if (os_cnt_r == OS_LAST)
        os_run_r <= 1'b0; // see [RQ8]
    end else begin
      os_pre_r <= os_pre_r + 16'h0001;
    end
  end

  // not retriggerable: an edge inside the window only marks a short interval
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rec_clk_r    <= 1'b0;
      short_seen_r <= 1'b0;
    end else begin
      if (edge_start && !os_run_r)
        rec_clk_r <= 1'b1; // see [RQ7]
      else if (os_fire)
        rec_clk_r <= 1'b0; // see [RQ8]
      if (edge_start && os_run_r)
        short_seen_r <= 1'b1; // see [RQ9]
      else if (edge_start)
        short_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      data_bit_r <= 1'b0;
    end else if (os_fire) begin
      data_bit_r <= short_seen_r || (edge_start && os_run_r); // see [RQ9]
    end
  end

  assign rec_rise  = edge_start && !os_run_r;
  assign bit_ready = rec_rise;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      TAPE_READ_DATA_O <= 1'b0;
      REC_CLK_O        <= 1'b0;
    end else begin
      REC_CLK_O <= rec_clk_r;
      if (rs232_mode)
        TAPE_READ_DATA_O <= 1'b1;        // see [RQ6]
      else if (rec_rise)
        TAPE_READ_DATA_O <= data_bit_r;  // see [RQ10]
    end
  end

  // ---------------- frequency multiplier and lock ----------------
  assign fb_shift  = baud_300 ? FB_SHIFT_300 : FB_SHIFT_1200; // see [RQ12]
  assign half_step = per_meas_r >> (fb_shift + 3'h1);         // see [RQ11]
  assign per_diff  = (per_cnt_r > per_meas_r) ? per_cnt_r - per_meas_r : per_meas_r - per_cnt_r;
  assign per_match = per_diff <= (per_meas_r >> LOCK_TOL_SHIFT);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      per_cnt_r  <= {PER_W{1'b0}};
      per_meas_r <= {PER_W{1'b0}};
      per_prev_r <= {PER_W{1'b0}};
    end else if (rec_rise) begin
      per_cnt_r  <= {{(PER_W-1){1'b0}}, 1'b1};
      per_meas_r <= per_cnt_r; // see [RQ11]
      per_prev_r <= per_meas_r;
    end else if (per_cnt_r != {PER_W{1'b1}}) begin
      per_cnt_r <= per_cnt_r + {{(PER_W-1){1'b0}}, 1'b1};
    end
  end

  // output phase realigned on each recovered clock rising edge, like a loop locking
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      mul_cnt_r <= {PER_W{1'b0}};
      mul_clk_r <= 1'b0;
    end else if (rec_rise) begin
      mul_cnt_r <= {PER_W{1'b0}};
      mul_clk_r <= 1'b1; // see [RQ11]
    end else if (half_step != {PER_W{1'b0}} && mul_cnt_r >= half_step - {{(PER_W-1){1'b0}}, 1'b1}) begin
      mul_cnt_r <= {PER_W{1'b0}};
      mul_clk_r <= !mul_clk_r; // see [RQ11]
    end else begin
      mul_cnt_r <= mul_cnt_r + {{(PER_W-1){1'b0}}, 1'b1};
    end
  end

  // lock needs several matching periods; a single odd period is a glitch
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      good_cnt_r <= 3'h0;
      miss_cnt_r <= 2'h0;
      lock_r     <= 1'b0;
      LOCK_O     <= 1'b0;
    end else begin
      if (rec_rise) begin
        if (per_match) begin
          miss_cnt_r <= 2'h0;
          if (good_cnt_r != LOCK_NEED)
            good_cnt_r <= good_cnt_r + 3'h1;
          if (good_cnt_r == LOCK_NEED - 3'h1)
            lock_r <= 1'b1; // see [RQ13]
        end else begin
          good_cnt_r <= 3'h0;
          if (miss_cnt_r != LOCK_MISS)
            miss_cnt_r <= miss_cnt_r + 2'h1;
          if (miss_cnt_r == LOCK_MISS - 2'h1)
            lock_r <= 1'b0; // see [RQ13]
        end
      end
      LOCK_O <= lock_r;
    end
  end

endmodule

// ---- verification/tape_fsk_recovery_asserts.sv ----
// assertion checker for the cassette FSK recovery block
module tape_fsk_checker #(
  parameter int OS_STEP_1200 = 20,
  parameter int OS_STEP_300  = 10
) (
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic        HSEL_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic        HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic        HREADYOUT_O,
  input wire logic        HRESP_O,
  input wire logic        TAPE_IN_I,
  input wire logic        TAPE_READ_DATA_O,
  input wire logic        REC_CLK_O,
  input wire logic        DIV55_O,
  input wire logic [4:0]  CPG_O,
  input wire logic        LOCK_O
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W12 = 12 * OS_STEP_1200;
  localparam int W3  = 12 * OS_STEP_300;
  logic [5:0]  gap_r;
  logic        seen_r;
  logic [15:0] hi_r;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // first pulse after reset has no reference spacing
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      gap_r  <= 6'h00;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= DIV55_O ? 6'h00 : gap_r + 6'h01;
      seen_r <= seen_r | DIV55_O;
    end
  end
  // high time, small slack for one-shot start skew
  always_ff @(posedge CLK_I) begin
    if (RST_I) hi_r <= 16'h0000;
    else hi_r <= REC_CLK_O ? hi_r + 16'h0001 : 16'h0000;
  end
  property p_div55_gap;
    seen_r && (DIV55_O || gap_r == 6'h36) |-> DIV55_O && gap_r == 6'h36;
  endproperty
  a_div55_gap: assert property (p_div55_gap) else $error("divider spacing wrong");
  property p_cpg_step;
    $changed(CPG_O) |-> CPG_O == $past(CPG_O) + 5'h01 ##1 $stable(CPG_O) [*8];
  endproperty
  a_cpg_step: assert property (p_cpg_step) else $error("stage counter step wrong");
  property p_rd_zero;
    HRDATA_O != 32'h0 |-> $past(HSEL_I && HTRANS_I[1] && !HWRITE_I && HREADY_I);
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside read");
  property p_bus_ok;
    HREADYOUT_O && !HRESP_O;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or error");
  property p_rec_rise;
    $rose(REC_CLK_O) |-> $past(TAPE_IN_I, 3) != $past(TAPE_IN_I, 4);
  endproperty
  a_rec_rise: assert property (p_rec_rise) else $error("recovered clock without edge");
  property p_rec_width;
    $fell(REC_CLK_O) |-> (hi_r + 3 >= W12 && hi_r <= W12 + 3) || (hi_r + 3 >= W3 && hi_r <= W3 + 3);
  endproperty
  a_rec_width: assert property (p_rec_width) else $error("one-shot width wrong");
  property p_lock_hold;
    $rose(LOCK_O) |=> LOCK_O [*8];
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock glitch");
  property p_data_sync;
    $fell(TAPE_READ_DATA_O) |=> $rose(REC_CLK_O);
  endproperty
  a_data_sync: assert property (p_data_sync) else $error("read data off recovered clock");
  c_lock: cover property ($rose(LOCK_O));
  c_data_fall: cover property ($fell(TAPE_READ_DATA_O));
  c_read: cover property (HRDATA_O != 32'h0);
endmodule
bind tape_fsk_recovery tape_fsk_checker #(
  .OS_STEP_1200(OS_STEP_1200),
  .OS_STEP_300 (OS_STEP_300)
) i_chk (
  .CLK_I, .RST_I, .HSEL_I, .HTRANS_I, .HWRITE_I, .HREADY_I, .HRDATA_O, .HREADYOUT_O, .HRESP_O,
  .TAPE_IN_I, .TAPE_READ_DATA_O, .REC_CLK_O, .DIV55_O, .CPG_O, .LOCK_O
);

// ---- verification/tape_source_model.sv ----
// cassette player model driving the digitized tape level
module tape_source_model (
  input  wire logic clk_i,
  output logic      tape_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial tape_o = 1'b0;
  // one: 2n toggles g apart, zero: n toggles 2g apart, same bit time
  task automatic send(input logic b, input logic slow);
    int g;
    int n;
    g = slow ? 400 : 800;
    n = slow ? 8 : 1;
    for (int i = 0; i < (b ? 2 * n : n); i++) begin
      tape_o <= ~tape_o;
      repeat (b ? g : 2 * g) @(posedge clk_i);
    end
  endtask
endmodule

// ---- verification/tb_cassette_fsk_data_recovery.sv ----
// self-checking bench for the cassette FSK recovery block
module tb_cassette_fsk_data_recovery import tape_fsk_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK_I = 1'b0, RST_I = 1'b1, HSEL_I = 1'b0, HWRITE_I = 1'b0, HREADY_I;
  logic [31:0] HADDR_I = 32'h0, HWDATA_I = 32'h0, HRDATA_O, rd;
  logic [1:0]  HTRANS_I = 2'h0;
  logic [2:0]  HSIZE_I = 3'h2;
  logic        HREADYOUT_O, HRESP_O, TAPE_IN_I, TAPE_READ_DATA_O, REC_CLK_O, DIV55_O;
  logic        ENC_CLK_O, RX_CLK_O, TX_CLK_O, LOCK_O, IRQ_O;
  logic [4:0]  CPG_O;
  logic [6:0]  mon;
  int          fails = 0, total_checks = 0, p;
  assign mon = {IRQ_O, LOCK_O, RX_CLK_O, TX_CLK_O, ENC_CLK_O, DIV55_O, TAPE_READ_DATA_O};
  // single slave: its ready is the bus ready
  assign HREADY_I = HREADYOUT_O;
  always #4 CLK_I = ~CLK_I;
  // one-shot steps shortened, window 1200 or 600 clocks
  tape_fsk_recovery #(.OS_STEP_1200(100), .OS_STEP_300(50)) i_dut (
    .CLK_I, .RST_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HSIZE_I, .HWDATA_I, .HREADY_I,
    .HRDATA_O, .HREADYOUT_O, .HRESP_O, .TAPE_IN_I, .TAPE_READ_DATA_O, .REC_CLK_O, .DIV55_O,
    .CPG_O, .ENC_CLK_O, .RX_CLK_O, .TX_CLK_O, .LOCK_O, .IRQ_O
  );
  tape_source_model i_tape (.clk_i(CLK_I), .tape_o(TAPE_IN_I));
  task automatic end_of_test();
    if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK_I);
    HSEL_I <= 1'b1;
    HADDR_I <= {24'h0, a};
    HTRANS_I <= 2'h2;
    HWRITE_I <= w;
    do begin @(posedge CLK_I); n++; end while (HREADYOUT_O !== 1'b1 && n < 20);
    HSEL_I <= 1'b0;
    HTRANS_I <= 2'h0;
    HWDATA_I <= d;
    do begin @(posedge CLK_I); n++; end while (HREADYOUT_O !== 1'b1 && n < 40);
    rd = HRDATA_O;
    if (n >= 40) begin fails++; end_of_test(); end
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // period in clocks between two rises of one monitored output
  task automatic per(input int k);
    logic o;
    for (int i = 0; i < 2; i++) begin
      p = 0;
      o = 1'b1;
      while (!(mon[k] === 1'b1 && o === 1'b0) && p < 5000) begin
        o = mon[k];
        @(negedge CLK_I);
        p++;
      end
    end
    if (p >= 5000) begin fails++; end_of_test(); end
  endtask
  task automatic wt(input int k, input logic v);
    for (int i = 0; i < 40 && mon[k] !== v; i++) @(negedge CLK_I);
  endtask
  task automatic t_regs();
    rdc("ctrl", OFS_CTRL, {30'h0, CTRL_RESET});
    rdc("mask", OFS_IRQ_MASK, {29'h0, IRQ_MASK_RESET});
    bus(1'b1, OFS_IRQ_MASK, 32'h7);
    rdc("mask_rw", OFS_IRQ_MASK, 32'h7);
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    rdc("unmapped", 8'h20, 32'h0);
  endtask
  task automatic t_clocks(input logic s);
    bus(1'b1, OFS_CTRL, {30'h0, s, 1'b0});
    rdc("ctrl_rw", OFS_CTRL, {30'h0, s, 1'b0});
    per(1);
    chk("div55", 32'h37, p);
    per(2);
    chk("enc_clk", s ? 32'h6E0 : 32'h370, p);
    per(3);
    chk("tx_clk", s ? 32'h1B8 : 32'h6E, p);
  endtask
  task automatic t_decode(input logic s);
    bus(1'b1, OFS_CTRL, {30'h0, s, 1'b0});
    fork
      repeat (s ? 4 : 8) i_tape.send(1'b1, s);
      begin
        repeat (s ? 14000 : 9000) @(negedge CLK_I);
        per(4);
      end
    join
    @(negedge CLK_I);
    chk("rx_near_100", 32'h1, 32'(p >= 96 && p <= 104));
    chk("data_one", 32'h1, {31'h0, TAPE_READ_DATA_O});
    chk("lock", 32'h1, {31'h0, LOCK_O});
    repeat (2) i_tape.send(1'b0, s);
    @(negedge CLK_I);
    chk("data_zero", 32'h0, {31'h0, TAPE_READ_DATA_O});
  endtask
  task automatic t_irq();
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("irq_stat", 32'h3, rd & 32'h3);
    chk("irq_masked", 32'h0, {31'h0, IRQ_O});
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    wt(6, 1'b1);
    chk("irq_on", 32'h1, {31'h0, IRQ_O});
    bus(1'b1, OFS_IRQ_STAT, 32'h1);
    wt(6, 1'b0);
    chk("irq_clear", 32'h0, {31'h0, IRQ_O});
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("stat_w1c", 32'h0, rd & 32'h1);
  endtask
  task automatic t_serial();
    bus(1'b1, OFS_CTRL, 32'h1);
    wt(0, 1'b1);
    chk("serial_data", 32'h1, {31'h0, TAPE_READ_DATA_O});
    per(4);
    chk("serial_rx", 32'h6E, p);
  endtask
  initial begin
    repeat (8) @(posedge CLK_I);
    RST_I <= 1'b0;
    @(negedge CLK_I);
    chk("reset_data", 32'h0, {31'h0, TAPE_READ_DATA_O});
    t_regs();
    t_clocks(1'b0);
    t_clocks(1'b1);
    t_decode(1'b0);
    t_irq();
    t_decode(1'b1);
    t_serial();
    end_of_test();
  end
  initial begin
    repeat (95000) @(posedge CLK_I);
    fails++;
    end_of_test();
  end
endmodule
